//--- logic/iep_pkg.sv
// constants and carrier types of the interrupt enable and priority block
package iep_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int PRIO_W = 3;
  localparam int NUM_GRP = 3;
  localparam int NUM_SRC = NUM_GRP * DATA_W;
  localparam int SRC_IDX_W = 6;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_EN0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_EN1 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_EN4 = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_PRIORITY_CTRL_0 = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_FLAG0 = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FLAG1 = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_FLAG4 = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_EVT_STS = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_EVT_EN = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLR = 4'h9;

  // ----------------------------------------------------------------
  // enable bit positions
  // ----------------------------------------------------------------
  localparam int FLASH_OP_IRQ_EN = 15;
  localparam int CONV_DONE_IRQ_EN = 13;
  localparam int SERIAL_TX_IRQ_EN = 12;
  localparam int SERIAL_RX_IRQ_EN = 11;
  localparam int SPI_XFER_IRQ_EN = 10;
  localparam int SPI_FAULT_IRQ_EN = 9;
  localparam int TIMER_THREE_IRQ_EN = 8;
  localparam int TIMER_TWO_IRQ_EN = 7;
  localparam int TIMER_ONE_IRQ_EN = 3;
  localparam int OUT_COMPARE_IRQ_EN = 2;
  localparam int IN_CAPTURE_IRQ_EN = 1;
  localparam int EXT_IRQ_ZERO_EN = 0;
  localparam int EXT_IRQ_TWO_EN = 13;
  localparam int EXT_IRQ_ONE_EN = 4;
  localparam int PIN_CHANGE_IRQ_EN = 3;
  localparam int COMPARATOR_IRQ_EN = 2;
  localparam int I2C_MASTER_IRQ_EN = 1;
  localparam int I2C_SLAVE_IRQ_EN = 0;
  localparam int CHARGE_TIME_IRQ_EN = 13;
  localparam int VOLTAGE_DETECT_IRQ_EN = 8;
  localparam int SERIAL_ERROR_IRQ_EN = 1;

  localparam logic [DATA_W-1:0] EN0_MASK = 16'(
    (1 << FLASH_OP_IRQ_EN) | (1 << CONV_DONE_IRQ_EN) | (1 << SERIAL_TX_IRQ_EN) |
    (1 << SERIAL_RX_IRQ_EN) | (1 << SPI_XFER_IRQ_EN) | (1 << SPI_FAULT_IRQ_EN) |
    (1 << TIMER_THREE_IRQ_EN) | (1 << TIMER_TWO_IRQ_EN) | (1 << TIMER_ONE_IRQ_EN) |
    (1 << OUT_COMPARE_IRQ_EN) | (1 << IN_CAPTURE_IRQ_EN) | (1 << EXT_IRQ_ZERO_EN));
  localparam logic [DATA_W-1:0] EN1_MASK = 16'(
    (1 << EXT_IRQ_TWO_EN) | (1 << EXT_IRQ_ONE_EN) | (1 << PIN_CHANGE_IRQ_EN) |
    (1 << COMPARATOR_IRQ_EN) | (1 << I2C_MASTER_IRQ_EN) | (1 << I2C_SLAVE_IRQ_EN));
  localparam logic [DATA_W-1:0] EN4_MASK = 16'(
    (1 << CHARGE_TIME_IRQ_EN) | (1 << VOLTAGE_DETECT_IRQ_EN) | (1 << SERIAL_ERROR_IRQ_EN));
  localparam logic [NUM_SRC-1:0] SRC_MASK = {EN4_MASK, EN1_MASK, EN0_MASK};

  // ----------------------------------------------------------------
  // priority fields
  // ----------------------------------------------------------------
  localparam int TIMER_ONE_PRIORITY_LSB = 12;
  localparam int OUT_COMPARE_PRIORITY_LSB = 8;
  localparam int IN_CAPTURE_PRIORITY_LSB = 4;
  localparam int EXT_IRQ_ZERO_PRIORITY_LSB = 0;
  localparam logic [DATA_W-1:0] IRQ_PRIORITY_CTRL_0_MASK = 16'h7777;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h4;
  localparam logic [DATA_W-1:0] IRQ_PRIORITY_CTRL_0_RST = 16'h4444;

  // ----------------------------------------------------------------
  // reset values and event bits
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] EN_RST = 16'h0000;
  localparam logic [DATA_W-1:0] REG_ZERO = 16'h0000;
  localparam int EVT_REQ_RISE = 0;
  localparam int EVT_LEVEL_CHG = 1;
  localparam int EVT_BLOCKED = 2;
  localparam logic [DATA_W-1:0] EVT_MASK = 16'h0007;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } iep_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [PRIO_W-1:0] level;
    logic [SRC_IDX_W-1:0] src;
  } iep_core_req_t;
endpackage

//--- logic/iep_src_slot.sv
// one interrupt source: hardware-set flag and its qualified request
`timescale 1ns/1ns
`default_nettype none
module iep_src_slot #(
  parameter int PW = 3
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic hw_event, // source event pulse
  input wire logic sw_write, // software writes this flag
  input wire logic sw_value, // value written
  input wire logic enable, // enable bit
  input wire logic [PW-1:0] priority_lvl, // priority field
  output logic flag, // flag state
  output logic request // qualified request
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (sw_write) begin
      flag_next = sw_value;
    end
    if (hw_event) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
  assign request = flag_reg & enable & (|priority_lvl);
endmodule // iep_src_slot
`default_nettype wire

//--- logic/iep_prio_pick.sv
// highest-level pick among qualified requests
`timescale 1ns/1ns
`default_nettype none
module iep_prio_pick #(
  parameter int N = 48,
  parameter int PW = 3,
  parameter int IW = 6
) (
  input wire logic [N-1:0] req, // qualified requests
  input wire logic [N*PW-1:0] levels, // level per source
  output logic any, // some request present
  output logic [PW-1:0] level, // winning level
  output logic [IW-1:0] index // winning source
);
  // highest level, lowest index on ties
  always_comb begin
    logic [PW-1:0] cur;
    cur = '0;
    any = 1'b0;
    level = '0;
    index = '0;
    for (int i = 0; i < N; i++) begin
      cur = levels[i*PW +: PW];
      if (req[i] && (!any || cur > level)) begin
        any = 1'b1;
        level = cur;
        index = IW'(i);
      end
    end
  end
endmodule // iep_prio_pick
`default_nettype wire

//--- logic/iep_top.sv
// interrupt enable and priority registers with request qualification
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - An enable bit of one passes its source's request, zero blocks it, and all enables clear at reset.
// - Unimplemented bits of enable and priority registers read zero and ignore writes.
// - The first enable register holds flash, converter, serial tx/rx, spi, timer, capture/compare and external 0 enables.
// - The second enable register holds external 2 and 1, pin change, comparator and i2c enables.
// - A three-bit priority field gives level 1 to 7, with 7 the highest.
// - A priority of zero stops the source from reaching the core regardless of its enable.
// - Every priority field resets to level 4.
// - The first priority register holds timer 1, compare 1, capture 1 and external 0 levels.
// - Each source has a flag set by its event and readable and writable by software.
module iep_top (
  input wire logic clk_sys, // system clock, 125 MHz
  input wire logic rst_n, // async reset, active low
  input wire iep_pkg::iep_bus_req_t bus_req, // register port request
  output logic [iep_pkg::DATA_W-1:0] bus_rdata, // read data, one cycle after read
  input wire logic [iep_pkg::NUM_SRC-1:0] src_event, // event pulses from sources
  output iep_pkg::iep_core_req_t core_req, // request to the core
  output logic irq_out // block event interrupt
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [iep_pkg::DATA_W-1:0] en0_reg, en0_next;
  logic [iep_pkg::DATA_W-1:0] en1_reg, en1_next;
  logic [iep_pkg::DATA_W-1:0] en4_reg, en4_next;
  logic [iep_pkg::DATA_W-1:0] irq_priority_ctrl_0_reg, irq_priority_ctrl_0_next;
  logic [iep_pkg::DATA_W-1:0] evt_sts_reg, evt_sts_next;
  logic [iep_pkg::DATA_W-1:0] evt_en_reg, evt_en_next;
  logic [iep_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  iep_pkg::iep_core_req_t core_reg, core_next;

  logic [iep_pkg::NUM_SRC-1:0] en_vec;
  logic [iep_pkg::NUM_SRC-1:0] flag_vec;
  logic [iep_pkg::NUM_SRC-1:0] req_vec;
  logic [iep_pkg::NUM_SRC-1:0] able_vec;
  logic [iep_pkg::NUM_SRC-1:0] flag_wr_vec;
  logic [iep_pkg::NUM_SRC*iep_pkg::PRIO_W-1:0] lvl_vec;
  logic pick_any;
  logic [iep_pkg::PRIO_W-1:0] pick_level;
  logic [iep_pkg::SRC_IDX_W-1:0] pick_index;
  logic [iep_pkg::DATA_W-1:0] evt_set;
  logic wr_en0, wr_en1, wr_en4, wr_irq_priority_ctrl_0;
  logic wr_flag0, wr_flag1, wr_flag4, wr_evt_en, wr_evt_clr;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_en0 = bus_req.wr && (bus_req.addr == iep_pkg::OFS_EN0);
  assign wr_en1 = bus_req.wr && (bus_req.addr == iep_pkg::OFS_EN1);
  assign wr_en4 = bus_req.wr && (bus_req.addr == iep_pkg::OFS_EN4);
  assign wr_irq_priority_ctrl_0 = bus_req.wr && (bus_req.addr == iep_pkg::OFS_IRQ_PRIORITY_CTRL_0);
  assign wr_flag0 = bus_req.wr && (bus_req.addr == iep_pkg::OFS_FLAG0);
  assign wr_flag1 = bus_req.wr && (bus_req.addr == iep_pkg::OFS_FLAG1);
  assign wr_flag4 = bus_req.wr && (bus_req.addr == iep_pkg::OFS_FLAG4);
  assign wr_evt_en = bus_req.wr && (bus_req.addr == iep_pkg::OFS_EVT_EN);
  assign wr_evt_clr = bus_req.wr && (bus_req.addr == iep_pkg::OFS_EVT_CLR);
  assign flag_wr_vec = {{iep_pkg::DATA_W{wr_flag4}}, {iep_pkg::DATA_W{wr_flag1}}, {iep_pkg::DATA_W{wr_flag0}}};

  // ----------------------------------------------------------------
  // enable and priority registers
  // ----------------------------------------------------------------
  always_comb begin
    en0_next = en0_reg;
    en1_next = en1_reg;
    en4_next = en4_reg;
    irq_priority_ctrl_0_next = irq_priority_ctrl_0_reg;
    if (wr_en0) begin
      en0_next = bus_req.wdata & iep_pkg::EN0_MASK;
    end
    if (wr_en1) begin
      en1_next = bus_req.wdata & iep_pkg::EN1_MASK;
    end
    if (wr_en4) begin
      en4_next = bus_req.wdata & iep_pkg::EN4_MASK;
    end
    if (wr_irq_priority_ctrl_0) begin
      irq_priority_ctrl_0_next = bus_req.wdata & iep_pkg::IRQ_PRIORITY_CTRL_0_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en0_reg <= iep_pkg::EN_RST;
      en1_reg <= iep_pkg::EN_RST;
      en4_reg <= iep_pkg::EN_RST;
      irq_priority_ctrl_0_reg <= iep_pkg::IRQ_PRIORITY_CTRL_0_RST;
    end else begin
      en0_reg <= en0_next;
      en1_reg <= en1_next;
      en4_reg <= en4_next;
      irq_priority_ctrl_0_reg <= irq_priority_ctrl_0_next;
    end
  end

  assign en_vec = {en4_reg, en1_reg, en0_reg};

  // ----------------------------------------------------------------
  // per-source slots
  // ----------------------------------------------------------------
  // sources whose priority field lives outside this block run at the reset level
  genvar gi;
  generate
    for (gi = 0; gi < iep_pkg::NUM_SRC; gi++) begin : g_src
      // field placement in the first priority register
      if (gi == iep_pkg::TIMER_ONE_IRQ_EN) begin : g_t1
        assign lvl_vec[gi*iep_pkg::PRIO_W +: iep_pkg::PRIO_W] =
          irq_priority_ctrl_0_reg[iep_pkg::TIMER_ONE_PRIORITY_LSB +: iep_pkg::PRIO_W];
      end else if (gi == iep_pkg::OUT_COMPARE_IRQ_EN) begin : g_oc
        assign lvl_vec[gi*iep_pkg::PRIO_W +: iep_pkg::PRIO_W] =
          irq_priority_ctrl_0_reg[iep_pkg::OUT_COMPARE_PRIORITY_LSB +: iep_pkg::PRIO_W];
      end else if (gi == iep_pkg::IN_CAPTURE_IRQ_EN) begin : g_ic
        assign lvl_vec[gi*iep_pkg::PRIO_W +: iep_pkg::PRIO_W] =
          irq_priority_ctrl_0_reg[iep_pkg::IN_CAPTURE_PRIORITY_LSB +: iep_pkg::PRIO_W];
      end else if (gi == iep_pkg::EXT_IRQ_ZERO_EN) begin : g_e0
        assign lvl_vec[gi*iep_pkg::PRIO_W +: iep_pkg::PRIO_W] =
          irq_priority_ctrl_0_reg[iep_pkg::EXT_IRQ_ZERO_PRIORITY_LSB +: iep_pkg::PRIO_W];
      end else begin : g_fix
        assign lvl_vec[gi*iep_pkg::PRIO_W +: iep_pkg::PRIO_W] = iep_pkg::PRIO_RST;
      end

      if (iep_pkg::SRC_MASK[gi]) begin : g_slot
        assign able_vec[gi] = en_vec[gi] && (lvl_vec[gi*iep_pkg::PRIO_W +: iep_pkg::PRIO_W] != iep_pkg::PRIO_OFF);
        iep_src_slot #(
          .PW(iep_pkg::PRIO_W)
        ) u_slot (
          .clk_sys(clk_sys),
          .rst_n(rst_n),
          .hw_event(src_event[gi]),
          .sw_write(flag_wr_vec[gi]),
          .sw_value(bus_req.wdata[gi % iep_pkg::DATA_W]),
          .enable(en_vec[gi]),
          .priority_lvl(lvl_vec[gi*iep_pkg::PRIO_W +: iep_pkg::PRIO_W]),
          .flag(flag_vec[gi]),
          .request(req_vec[gi])
        );
      end else begin : g_none
        assign able_vec[gi] = 1'b0;
        assign flag_vec[gi] = 1'b0;
        assign req_vec[gi] = 1'b0;
      end
    end
  endgenerate

  iep_prio_pick #(
    .N(iep_pkg::NUM_SRC),
    .PW(iep_pkg::PRIO_W),
    .IW(iep_pkg::SRC_IDX_W)
  ) u_pick (
    .req(req_vec),
    .levels(lvl_vec),
    .any(pick_any),
    .level(pick_level),
    .index(pick_index)
  );

  // ----------------------------------------------------------------
  // core request and block events
  // ----------------------------------------------------------------
  always_comb begin
    core_next.valid = pick_any;
    core_next.level = pick_any ? pick_level : iep_pkg::PRIO_OFF;
    core_next.src = pick_any ? pick_index : '0;
    evt_set = iep_pkg::REG_ZERO;
    evt_set[iep_pkg::EVT_REQ_RISE] = pick_any && !core_reg.valid;
    evt_set[iep_pkg::EVT_LEVEL_CHG] = pick_any && core_reg.valid && (pick_level != core_reg.level);
    // an event that cannot reach the core is worth telling software about
    evt_set[iep_pkg::EVT_BLOCKED] = |(src_event & iep_pkg::SRC_MASK & ~able_vec);
    evt_en_next = wr_evt_en ? (bus_req.wdata & iep_pkg::EVT_MASK) : evt_en_reg;
    evt_sts_next = evt_sts_reg;
    if (wr_evt_clr) begin
      evt_sts_next = evt_sts_reg & ~bus_req.wdata;
    end
    // set wins over a clear in the same cycle
    evt_sts_next = evt_sts_next | evt_set;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_reg <= '0;
      evt_sts_reg <= iep_pkg::REG_ZERO;
      evt_en_reg <= iep_pkg::REG_ZERO;
    end else begin
      core_reg <= core_next;
      evt_sts_reg <= evt_sts_next;
      evt_en_reg <= evt_en_next;
    end
  end

  assign core_req = core_reg;
  assign irq_out = |(evt_sts_reg & evt_en_reg);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = iep_pkg::REG_ZERO;
    if (bus_req.rd) begin
      case (bus_req.addr)
        iep_pkg::OFS_EN0: rdata_next = en0_reg;
        iep_pkg::OFS_EN1: rdata_next = en1_reg;
        iep_pkg::OFS_EN4: rdata_next = en4_reg;
        iep_pkg::OFS_IRQ_PRIORITY_CTRL_0: rdata_next = irq_priority_ctrl_0_reg;
        iep_pkg::OFS_FLAG0: rdata_next = flag_vec[0 +: iep_pkg::DATA_W];
        iep_pkg::OFS_FLAG1: rdata_next = flag_vec[iep_pkg::DATA_W +: iep_pkg::DATA_W];
        iep_pkg::OFS_FLAG4: rdata_next = flag_vec[2*iep_pkg::DATA_W +: iep_pkg::DATA_W];
        iep_pkg::OFS_EVT_STS: rdata_next = evt_sts_reg;
        iep_pkg::OFS_EVT_EN: rdata_next = evt_en_reg;
        default: rdata_next = iep_pkg::REG_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= iep_pkg::REG_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_enable_reset: assert property ($rose(rst_n) |-> (en_vec == '0))
    else $error("enables not clear after reset");
  chk_enable_blocks: assert property (!en_vec[iep_pkg::TIMER_ONE_IRQ_EN] |-> !req_vec[iep_pkg::TIMER_ONE_IRQ_EN])
    else $error("disabled source still requests");
  chk_unimpl_read: assert property ((bus_req.rd && bus_req.addr == iep_pkg::OFS_IRQ_PRIORITY_CTRL_0)
    |=> ((bus_rdata & ~iep_pkg::IRQ_PRIORITY_CTRL_0_MASK) == '0))
    else $error("unimplemented priority bits read nonzero");
  chk_en0_write: assert property (wr_en0 |=> (en0_reg == ($past(bus_req.wdata) & iep_pkg::EN0_MASK)))
    else $error("first enable register write wrong");
  chk_en1_write: assert property (wr_en1 |=> (en1_reg == ($past(bus_req.wdata) & iep_pkg::EN1_MASK)))
    else $error("second enable register write wrong");
  chk_en4_write: assert property (wr_en4 |=> (en4_reg == ($past(bus_req.wdata) & iep_pkg::EN4_MASK)))
    else $error("third enable register write wrong");
  chk_level_report: assert property ((req_vec == 48'h0000_0000_0008)
    |=> (core_req.valid && core_req.level == $past(irq_priority_ctrl_0_reg[14:12]) && core_req.src == 6'h03))
    else $error("reported level differs from field");
  chk_prio_zero_off: assert property ((irq_priority_ctrl_0_reg[14:12] == 3'h0) |-> !req_vec[iep_pkg::TIMER_ONE_IRQ_EN])
    else $error("zero priority source requests");
  chk_prio_reset: assert property ($rose(rst_n) |-> (irq_priority_ctrl_0_reg == 16'h4444))
    else $error("priority reset value wrong");
  chk_field_place: assert property (wr_irq_priority_ctrl_0 |=> (lvl_vec[5:3] == $past(bus_req.wdata[6:4])
    && lvl_vec[11:9] == $past(bus_req.wdata[14:12])))
    else $error("priority field placement wrong");
  chk_flag_set: assert property (src_event[iep_pkg::TIMER_ONE_IRQ_EN] |=> flag_vec[iep_pkg::TIMER_ONE_IRQ_EN])
    else $error("event did not set flag");
  chk_core_gate: assert property ((|req_vec) |=> core_req.valid)
    else $error("request not presented to core");
  chk_core_quiet: assert property (!(|req_vec) |=> !core_req.valid)
    else $error("core request without qualified source");

  cov_top_level: cover property (core_req.valid && core_req.level == 3'h7);
  cov_blocked: cover property (evt_set[iep_pkg::EVT_BLOCKED]);
  cov_set_clear: cover property (wr_evt_clr && |evt_set);
  cov_irq_rise: cover property ($rose(irq_out));
endmodule // iep_top
`default_nettype wire

//--- logic/iep_placeholder_unused.sv
// intentionally empty compilation unit
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- bench/iep_core_model.sv
// model of the processor core that takes prioritised requests
`timescale 1ns/1ns
`default_nettype none
module iep_core_model (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire iep_pkg::iep_core_req_t core_req, // request from the block
  output logic [iep_pkg::PRIO_W-1:0] taken_level, // level last taken
  output logic [iep_pkg::SRC_IDX_W-1:0] taken_src // source last taken
);
  // ----------------------------------------------------------------
  // acceptance
  // ----------------------------------------------------------------
  // core takes any standing request at once, so no back-pressure exists
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      taken_level <= 3'h0;
      taken_src <= 6'h00;
    end else if (core_req.valid) begin
      taken_level <= core_req.level;
      taken_src <= core_req.src;
    end
  end
endmodule // iep_core_model
`default_nettype wire

//--- bench/tb_iep_top.sv
// self-checking bench of the interrupt enable and priority block
`timescale 1ns/1ns
`default_nettype none
module tb_iep_top;
  logic clk_sys;
  logic rst_n;
  iep_pkg::iep_bus_req_t bus_req;
  logic [15:0] bus_rdata;
  logic [47:0] src_event;
  iep_pkg::iep_core_req_t core_req;
  logic irq_out;
  logic [2:0] taken_level;
  logic [5:0] taken_src;
  int err_total;
  int n_compared;
  int cyc;

  iep_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .src_event(src_event), .core_req(core_req), .irq_out(irq_out));
  iep_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .core_req(core_req),
    .taken_level(taken_level), .taken_src(taken_src));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    cmp(what, exp, bus_rdata);
  endtask

  task automatic fire(input logic [47:0] ev);
    @(posedge clk_sys);
    src_event <= ev;
    @(posedge clk_sys);
    src_event <= 48'h0;
  endtask

  // margin of two cycles: of the two-cycle request latency one has passed when the task starts
  task automatic chk_core(input logic v, input logic [2:0] lvl, input logic [5:0] src);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp("core valid", {15'h0000, v}, {15'h0000, core_req.valid});
    cmp("core level", {13'h0000, lvl}, {13'h0000, core_req.level});
    cmp("core src", {10'h000, src}, {10'h000, core_req.src});
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, well above the fewer than two hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    src_event = 48'h0;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'h0, 16'h0000, "enable0 reset");
    rd(4'h1, 16'h0000, "enable1 reset");
    rd(4'h2, 16'h0000, "enable4 reset");
    rd(4'h3, 16'h4444, "priority0 reset");
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000, "unmapped");
    wr(4'h0, 16'hFFFF);
    wr(4'h1, 16'hFFFF);
    wr(4'h2, 16'hFFFF);
    wr(4'h3, 16'hFFFF);
    rd(4'h0, 16'hBF8F, "enable0 bits");
    rd(4'h1, 16'h201F, "enable1 bits");
    rd(4'h2, 16'h2102, "enable4 bits");
    rd(4'h3, 16'h7777, "priority0 bits");
    // blocked source, then enabled: request and event interrupt
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h4444);
    wr(4'h8, 16'h0001);
    fire(48'h8);
    chk_core(1'b0, 3'h0, 6'h00);
    rd(4'h4, 16'h0008, "flag0");
    wr(4'h0, 16'h0008);
    chk_core(1'b1, 3'h4, 6'h03);
    rd(4'h7, 16'h0005, "event status");
    cmp("irq raised", 16'h0001, {15'h0000, irq_out});
    wr(4'h8, 16'h0000);
    chk_core(1'b1, 3'h4, 6'h03);
    cmp("irq masked", 16'h0000, {15'h0000, irq_out});
    wr(4'h9, 16'h0007);
    wr(4'h8, 16'h0007);
    rd(4'h7, 16'h0000, "status cleared");
    cmp("irq cleared", 16'h0000, {15'h0000, irq_out});
    // field positions and priority ordering
    wr(4'h0, 16'h000F);
    wr(4'h3, 16'h1235);
    fire(48'hF);
    chk_core(1'b1, 3'h5, 6'h00);
    cmp("core taken", 16'h0000, {10'h000, taken_src});
    wr(4'h3, 16'h1230);
    chk_core(1'b1, 3'h3, 6'h01);
    wr(4'h0, 16'h0005);
    chk_core(1'b1, 3'h2, 6'h02);
    wr(4'h0, 16'h000F);
    wr(4'h3, 16'h7000);
    chk_core(1'b1, 3'h7, 6'h03);
    cmp("core taken", 16'h0007, {13'h0000, taken_level});
    wr(4'h4, 16'h0000);
    chk_core(1'b0, 3'h0, 6'h00);
    // second and third enable groups reach the core
    wr(4'h1, 16'h2000);
    fire(48'h0000_2000_0000);
    chk_core(1'b1, 3'h4, 6'h1D);
    wr(4'h5, 16'h0000);
    wr(4'h2, 16'h0100);
    fire(48'h0100_0000_0000);
    chk_core(1'b1, 3'h4, 6'h28);
    // reset in mid-run
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    chk_core(1'b0, 3'h0, 6'h00);
    rd(4'h3, 16'h4444, "priority0 rerun");
    rd(4'h2, 16'h0000, "enable4 rerun");
    tally_and_finish();
  end
endmodule // tb_iep_top
`default_nettype wire
